// File: design/qba_pkg.sv
`default_nettype none

// Shared constants and carriers for the quad byte average unit.
package qba_pkg;

  // Register byte addresses on the APB slave.
  localparam logic [7:0] OFF_SRC0   = 8'h00;
  localparam logic [7:0] OFF_SRC1   = 8'h04;
  localparam logic [7:0] OFF_SRC2   = 8'h08;
  localparam logic [7:0] OFF_SRC3   = 8'h0C;
  localparam logic [7:0] OFF_IDX0   = 8'h10;
  localparam logic [7:0] OFF_IDX1   = 8'h14;
  localparam logic [7:0] OFF_CMD    = 8'h18;
  localparam logic [7:0] OFF_RESULT = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_ARITHMETIC_STATUS_WORD  = 8'h24;

  // Command word field positions.
  localparam int CMD_OP_BIT   = 0;
  localparam int CMD_DST_LSB  = 1;
  localparam int CMD_SRC0_LSB = 4;
  localparam int CMD_SRC1_LSB = 6;
  localparam int CMD_OPT_LSB  = 8;
  localparam int CMD_OPT_W    = 3;
  localparam int CMD_OPT_NUM  = 3;
  localparam int CMD_PAR_BIT  = 17;

  // Option slot codes; any slot may carry any code.
  localparam logic [2:0] OPT_NONE  = 3'h0;
  localparam logic [2:0] OPT_TRUNC = 3'h1;
  localparam logic [2:0] OPT_REV   = 3'h2;
  localparam logic [2:0] OPT_LOW   = 3'h3;
  localparam logic [2:0] OPT_HIGH  = 3'h4;

  // Source pair codes.
  localparam logic [1:0] PAIR_R10 = 2'h0;
  localparam logic [1:0] PAIR_R32 = 2'h1;

  // Status register bit positions.
  localparam int ST_DONE     = 0;
  localparam int ST_ILLEGAL  = 1;
  localparam int ST_LEN32    = 2;
  localparam int ST_PARALLEL = 3;
  localparam int ST_MISALIGN = 4;

  // Reset value and rounding mode bit position.
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam int          ARITHMETIC_STATUS_WORD_RND = 8;

  // Decoded operation carried from the decoder to the datapath.
  typedef struct packed {
    logic isHalf;
    logic trunc;
    logic rev;
    logic high;
    logic placed;
    logic bad;
  } qba_opts_t;

endpackage : qba_pkg

`default_nettype wire

// File: design/qba_quad_byte_average.sv
// Notes on behaviour
// - Index low bits pick four consecutive bytes 3..0, 4..1, 5..2 or 6..3.
// - Averaging never raises a misalignment exception.
// - Word average rounds the mean up when the byte sum is odd.
// - Truncate option drops the fractional part of each mean.
// - Low bytes come from the lower register, or the higher under reverse.
// - Reverse only swaps the two registers of a pair; alignment unchanged.
// - Word average applies truncate and reverse together.
// - Half-word average: upper mean from bytes 3,2, lower from 1,0 of both.
// - Half-word mean is four-byte sum shifted right by two.
// - Half-word average offers rounding or truncation of each mean.
// - Low placement writes means into bits 7..0 and 23..16.
// - High placement writes means into bits 31..24 and 15..8.
// - Half-word average zeroes the destination bytes without a mean.
// - Half-word average aligns both pairs from index register zero.
// - The global rounding mode bit is ignored by both averages.
// - Option order in the command does not change the operation.
// - Both averages decode as 32-bit instructions.
// - Both averages may issue alongside 16-bit instructions.
// - Word average forms four lane means pairing lane k with lane k.
// - Word lane mean is two-byte sum shifted right by one.
// - Word average aligns pair one by index zero, pair two by index one.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module qba_quad_byte_average (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        destWe,
  output var  logic [2:0]  destSel,
  output var  logic [31:0] destData
);

  // Address decode shared by reads and writes.
  function automatic logic isMapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= qba_pkg::OFF_ARITHMETIC_STATUS_WORD);
  endfunction

  // Option slots are ORed, so their order never matters.
  function automatic qba_pkg::qba_opts_t decodeOpts(input logic [31:0] c);
    qba_pkg::qba_opts_t o;
    logic [2:0]         code;
    o = '0;
    o.isHalf = c[qba_pkg::CMD_OP_BIT];
    for (int i = 0; i < qba_pkg::CMD_OPT_NUM; i++) begin
      code = c[qba_pkg::CMD_OPT_LSB + qba_pkg::CMD_OPT_W * i +: 3];
      case (code)
        qba_pkg::OPT_NONE:  o.bad = o.bad;
        qba_pkg::OPT_TRUNC: o.trunc = 1'b1;
        qba_pkg::OPT_REV:   o.rev = 1'b1;
        qba_pkg::OPT_LOW:   o.placed = 1'b1;
        qba_pkg::OPT_HIGH: begin
          o.high   = 1'b1;
          o.placed = 1'b1;
        end
        default:            o.bad = 1'b1;
      endcase
    end
    return o;
  endfunction

  // Eight-byte view of a pair, with the registers swapped under reverse.
  function automatic logic [31:0] alignPair(input logic [31:0] lo,
                                            input logic [31:0] hi,
                                            input logic        rev,
                                            input logic [1:0]  sh);
    logic [63:0] view;
    view = rev ? {lo, hi} : {hi, lo};
    return view[8 * sh +: 32];
  endfunction

  // Two-byte mean; the carry-in of one rounds odd sums upward.
  function automatic logic [7:0] avg2(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       t);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ~t};
    return s[8:1];
  endfunction

  // Four-byte mean; adding two before the shift rounds half up.
  function automatic logic [7:0] avg4(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic [7:0] c,
                                      input logic [7:0] d,
                                      input logic       t);
    logic [9:0] s;
    s = {2'h0, a} + {2'h0, b} + {2'h0, c} + {2'h0, d} + {8'h00, ~t, 1'b0};
    return s[9:2];
  endfunction

  logic [31:0]        srcReg_q [4];
  logic [31:0]        idx0_q;
  logic [31:0]        idx1_q;
  logic [31:0]        cmd_q;
  logic [31:0]        result_q;
  logic [31:0]        status_q;
  logic [31:0]        arithmetic_status_word_q;
  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  logic               destWe_q;
  logic [2:0]         destSel_q;
  logic [31:0]        readMux;
  logic               wrDone;
  logic               issue;
  logic               illegal;
  logic               issueOk;
  qba_pkg::qba_opts_t curOpts;
  logic [1:0]         pairSel0;
  logic [1:0]         pairSel1;
  logic [31:0]        pair0Lo;
  logic [31:0]        pair0Hi;
  logic [31:0]        pair1Lo;
  logic [31:0]        pair1Hi;
  logic [1:0]         shift1;
  logic [31:0]        aligned0;
  logic [31:0]        aligned1;
  logic [31:0]        wordMean;
  logic [7:0]         halfMean [2];
  logic [31:0]        halfWord;
  logic [31:0]        nextResult;

  // A write completes on the second access cycle, when pready is high.
  assign wrDone  = psel && penable && pready_q && pwrite && isMapped(paddr);
  assign issue   = wrDone && (paddr == qba_pkg::OFF_CMD);
  assign curOpts = decodeOpts(pwdata);
  assign pairSel0 = pwdata[qba_pkg::CMD_SRC0_LSB +: 2];
  assign pairSel1 = pwdata[qba_pkg::CMD_SRC1_LSB +: 2];

  // Pairs other than 1:0 and 3:2 are refused rather than guessed at.
  assign illegal = curOpts.bad || (pairSel0 > qba_pkg::PAIR_R32)
                 || (pairSel1 > qba_pkg::PAIR_R32)
                 || (!curOpts.isHalf && curOpts.placed);
  assign issueOk = issue && !illegal;

  // Operand pairs from the data register copies.
  assign pair0Lo = srcReg_q[{pairSel0[0], 1'b0}];
  assign pair0Hi = srcReg_q[{pairSel0[0], 1'b1}];
  assign pair1Lo = srcReg_q[{pairSel1[0], 1'b0}];
  assign pair1Hi = srcReg_q[{pairSel1[0], 1'b1}];

  // Half-word average shares index zero for both pairs.
  assign shift1   = curOpts.isHalf ? idx0_q[1:0] : idx1_q[1:0];
  assign aligned0 = alignPair(pair0Lo, pair0Hi, curOpts.rev, idx0_q[1:0]);
  assign aligned1 = alignPair(pair1Lo, pair1Hi, curOpts.rev, shift1);

  // Four independent lane means for the word-result average.
  genvar g;
  for (g = 0; g < 4; g++) begin : gLane
    assign wordMean[8 * g +: 8] = avg2(aligned0[8 * g +: 8],
                                       aligned1[8 * g +: 8], curOpts.trunc);
  end

  // Two four-byte means for the half-word-result average.
  for (g = 0; g < 2; g++) begin : gHalf
    assign halfMean[g] = avg4(aligned0[16 * g +: 8], aligned0[16 * g + 8 +: 8],
                              aligned1[16 * g +: 8], aligned1[16 * g + 8 +: 8],
                              curOpts.trunc);
  end

  // Unused bytes are zero; placement picks the byte of each half-word.
  assign halfWord = curOpts.high
                  ? {halfMean[1], 8'h00, halfMean[0], 8'h00}
                  : {8'h00, halfMean[1], 8'h00, halfMean[0]};
  // The rounding mode bit in arithmetic_status_word_q is never consulted here.
  assign nextResult = curOpts.isHalf ? halfWord : wordMean;

  // Source data registers and index registers, written from the bus.
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < 4; i++) begin
        srcReg_q[i] <= qba_pkg::RST_WORD;
      end
      idx0_q <= qba_pkg::RST_WORD;
      idx1_q <= qba_pkg::RST_WORD;
    end else if (wrDone) begin
      for (int i = 0; i < 4; i++) begin
        if (paddr == qba_pkg::OFF_SRC0 + 8'(4 * i)) begin
          srcReg_q[i] <= pwdata;
        end
      end
      if (paddr == qba_pkg::OFF_IDX0) begin
        idx0_q <= pwdata;
      end
      if (paddr == qba_pkg::OFF_IDX1) begin
        idx1_q <= pwdata;
      end
    end
  end

  // Arithmetic status is software state only; an issue never touches it.
  always_ff @(posedge clock) begin
    if (srst) begin
      arithmetic_status_word_q <= qba_pkg::RST_WORD;
    end else if (wrDone && paddr == qba_pkg::OFF_ARITHMETIC_STATUS_WORD) begin
      arithmetic_status_word_q <= pwdata;
    end
  end

  // Command and status settle at the issuing write edge; result too, unless the command is illegal.
  always_ff @(posedge clock) begin
    if (srst) begin
      cmd_q    <= qba_pkg::RST_WORD;
      result_q <= qba_pkg::RST_WORD;
      status_q <= qba_pkg::RST_WORD;
    end else if (issue) begin
      cmd_q <= pwdata;
      if (!illegal) begin
        result_q <= nextResult;
      end
      status_q <= '0;
      status_q[qba_pkg::ST_DONE]     <= !illegal;
      status_q[qba_pkg::ST_ILLEGAL]  <= illegal;
      status_q[qba_pkg::ST_LEN32]    <= 1'b1;
      status_q[qba_pkg::ST_PARALLEL] <= pwdata[qba_pkg::CMD_PAR_BIT];
      // Alignment is done inside the pairs, so no fault is ever flagged.
      status_q[qba_pkg::ST_MISALIGN] <= 1'b0;
    end
  end

  // Destination write port: one pulse per legal issue.
  always_ff @(posedge clock) begin
    if (srst) begin
      destWe_q  <= 1'b0;
      destSel_q <= 3'h0;
    end else begin
      destWe_q <= issueOk;
      if (issueOk) begin
        destSel_q <= pwdata[qba_pkg::CMD_DST_LSB +: 3];
      end
    end
  end

  // Read multiplexer over the register map.
  always_comb begin
    readMux = qba_pkg::RST_WORD;
    case (paddr)
      qba_pkg::OFF_SRC0:   readMux = srcReg_q[0];
      qba_pkg::OFF_SRC1:   readMux = srcReg_q[1];
      qba_pkg::OFF_SRC2:   readMux = srcReg_q[2];
      qba_pkg::OFF_SRC3:   readMux = srcReg_q[3];
      qba_pkg::OFF_IDX0:   readMux = idx0_q;
      qba_pkg::OFF_IDX1:   readMux = idx1_q;
      qba_pkg::OFF_CMD:    readMux = cmd_q;
      qba_pkg::OFF_RESULT: readMux = result_q;
      qba_pkg::OFF_STATUS: readMux = status_q;
      qba_pkg::OFF_ARITHMETIC_STATUS_WORD:  readMux = arithmetic_status_word_q;
      default:             readMux = qba_pkg::RST_WORD;
    endcase
  end

  // One wait state keeps every APB output registered.
  always_ff @(posedge clock) begin
    if (srst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= qba_pkg::RST_WORD;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !isMapped(paddr);
      if (psel && penable && !pready_q && !pwrite) begin
        prdata_q <= readMux;
      end
    end
  end

  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = pslverr_q;
  assign destWe   = destWe_q;
  assign destSel  = destSel_q;
  assign destData = result_q;

  // Checks on the datapath and the bus answer.
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_round_up_mean: assert property (
    issueOk && !curOpts.isHalf && !curOpts.trunc && !curOpts.rev && pairSel0 == 2'h0
    && pairSel1 == 2'h1 && idx0_q[1:0] == 2'h0 && idx1_q[1:0] == 2'h0
    |=> destData[31:24] == 8'((9'($past(srcReg_q[0][31:24]))
                              + 9'($past(srcReg_q[2][31:24])) + 9'h001) >> 1))
    else $error("word mean not rounded up");

  a_trunc_align_sel: assert property (
    issueOk && !curOpts.isHalf && curOpts.trunc && !curOpts.rev && pairSel0 == 2'h0
    && pairSel1 == 2'h1 && idx0_q[1:0] == 2'h3 && idx1_q[1:0] == 2'h3
    |=> destData[7:0] == 8'((9'($past(srcReg_q[0][31:24]))
                            + 9'($past(srcReg_q[2][31:24]))) >> 1))
    else $error("aligned byte or truncation wrong");

  a_rev_trunc_lane: assert property (
    issueOk && !curOpts.isHalf && curOpts.trunc && curOpts.rev && pairSel0 == 2'h0
    && pairSel1 == 2'h1 && idx0_q[1:0] == 2'h0 && idx1_q[1:0] == 2'h0
    |=> destData[15:8] == 8'((9'($past(srcReg_q[1][15:8])) + 9'($past(srcReg_q[3][15:8])))
                             >> 1))
    else $error("reverse with truncate wrong");

  a_half_low_mean: assert property (
    issueOk && curOpts.isHalf && curOpts.trunc && !curOpts.high && !curOpts.rev
    && pairSel0 == 2'h0 && pairSel1 == 2'h1 && idx0_q[1:0] == 2'h0
    |=> destData[7:0] == 8'((10'($past(srcReg_q[0][7:0])) + 10'($past(srcReg_q[0][15:8]))
                            + 10'($past(srcReg_q[2][7:0])) + 10'($past(srcReg_q[2][15:8])))
                            >> 2))
    else $error("half-word mean wrong");

  a_half_zero_low: assert property (
    issueOk && curOpts.isHalf && !curOpts.high
    |=> destData[31:24] == 8'h00 && destData[15:8] == 8'h00)
    else $error("low placement leaves nonzero bytes");

  a_half_zero_high: assert property (
    issueOk && curOpts.isHalf && curOpts.high
    |=> destData[23:16] == 8'h00 && destData[7:0] == 8'h00)
    else $error("high placement leaves nonzero bytes");

  a_dest_on_issue: assert property (
    issueOk |=> destWe && destSel == $past(pwdata[3:1]) && arithmetic_status_word_q == $past(arithmetic_status_word_q))
    else $error("destination write missing or status changed");

  a_illegal_no_write: assert property (
    issue && illegal |=> !destWe && status_q[qba_pkg::ST_ILLEGAL])
    else $error("illegal pair was executed");

  a_no_misalign: assert property (
    issue |=> !status_q[qba_pkg::ST_MISALIGN] && status_q[qba_pkg::ST_LEN32])
    else $error("misalignment flagged");

  a_bus_answer: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("slave answer timing wrong");

  c_word_issue: cover property (issueOk && !curOpts.isHalf && curOpts.rev);
  c_half_high:  cover property (issueOk && curOpts.isHalf && curOpts.high);
  c_illegal:    cover property (issue && illegal);
  c_unmapped:   cover property (pslverr);

endmodule : qba_quad_byte_average

`default_nettype wire

// File: verification/qba_regfile_model.sv
`timescale 1ns/1ns
`default_nettype none

// Destination register file on the core side; it logs every write strobe it sees.
module qba_regfile_model (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        destWe,
  input  wire logic [2:0]  destSel,
  input  wire logic [31:0] destData,
  output var  logic [7:0]  wrCount_q,
  output var  logic [31:0] lastData_q,
  output var  logic [2:0]  lastSel_q
);
  // A strobe counts once for every cycle it is held high, so the bench sees stretched pulses.
  always_ff @(posedge clock) begin
    if (srst) begin
      wrCount_q  <= 8'h00;
      lastData_q <= 32'h0000_0000;
      lastSel_q  <= 3'h0;
    end else if (destWe) begin
      wrCount_q  <= wrCount_q + 8'h01;
      lastData_q <= destData;
      lastSel_q  <= destSel;
    end
  end
endmodule // qba_regfile_model

`default_nettype wire

// File: verification/quad_byte_average_unit_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module quad_byte_average_unit_tb_top;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        destWe;
  logic [2:0]  destSel;
  logic [31:0] destData;
  logic [7:0]  wrCount_q;
  logic [31:0] lastData_q;
  logic [2:0]  lastSel_q;
  logic        lastErr;
  int          n_fail = 0;
  int          compares = 0;
  logic [31:0] src [4] = '{32'h8F17_E203, 32'h5B29_C4F1, 32'h3A6D_0EB7, 32'hF4C8_7193};

  // Free-running core clock, 20 ns period.
  always #10 clock = ~clock;

  qba_quad_byte_average qba_quad_byte_average_inst (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .destWe(destWe), .destSel(destSel),
    .destData(destData));
  qba_regfile_model qba_regfile_model_inst (.clock(clock), .srst(srst), .destWe(destWe),
    .destSel(destSel), .destData(destData), .wrCount_q(wrCount_q), .lastData_q(lastData_q),
    .lastSel_q(lastSel_q));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Mismatches %0d of %0d compares", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One APB transfer; the request stands until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0000_0000, r);
  endtask

  function automatic logic [31:0] cmd(input logic op, input logic [2:0] dst,
      input logic [1:0] p0, input logic [1:0] p1, input logic [2:0] o0,
      input logic [2:0] o1, input logic [2:0] o2, input logic par);
    return {14'h0, par, o2, o1, o0, p1, p0, dst, op};
  endfunction

  // Eight-byte view of a pair, reversed on request, then four bytes from the shift.
  function automatic logic [31:0] pick(input logic [1:0] p, input logic rv, input logic [1:0] sh);
    logic [63:0] v;
    v = rv ? {src[2*p], src[2*p+1]} : {src[2*p+1], src[2*p]};
    return v[8*sh +: 32];
  endfunction

  function automatic logic [31:0] eWord(input logic [31:0] x, input logic [31:0] y, input logic t);
    logic [8:0]  s;
    logic [31:0] r;
    for (int k = 0; k < 4; k++) begin
      s = {1'b0, x[8*k +: 8]} + {1'b0, y[8*k +: 8]} + {8'h00, ~t};
      r[8*k +: 8] = s[8:1];
    end
    return r;
  endfunction

  function automatic logic [31:0] eHalf(input logic [31:0] x, input logic [31:0] y,
      input logic t, input logic h);
    logic [9:0] s1;
    logic [9:0] s0;
    s1 = 10'(x[31:24]) + x[23:16] + y[31:24] + y[23:16] + (t ? 10'h0 : 10'h2);
    s0 = 10'(x[15:8]) + x[7:0] + y[15:8] + y[7:0] + (t ? 10'h0 : 10'h2);
    return h ? {s1[9:2], 8'h00, s0[9:2], 8'h00} : {8'h00, s1[9:2], 8'h00, s0[9:2]};
  endfunction

  // Issue a command and judge the write the register file receives.
  task automatic issue(input logic [31:0] c, input logic [31:0] e, input logic [31:0] st);
    logic [7:0]  n0;
    logic [31:0] v;
    int          k;
    n0 = wrCount_q;
    k = 0;
    wr(qba_pkg::OFF_CMD, c);
    while (wrCount_q === n0 && k < 10) begin
      @(posedge clock);
      k++;
    end
    repeat (3) @(posedge clock);
    check({24'h0, wrCount_q}, {24'h0, n0 + 8'h01});
    check(lastData_q, e);
    check({29'h0, lastSel_q}, {29'h0, c[3:1]});
    rd(qba_pkg::OFF_RESULT, v);
    check(v, e);
    rd(qba_pkg::OFF_STATUS, v);
    check(v, st);
  endtask

  task automatic t_reset();
    logic [31:0] v;
    for (int a = 0; a <= 36; a += 4) begin
      rd(8'(a), v);
      check(v, 32'h0000_0000);
    end
    for (int i = 0; i < 4; i++) wr(8'(4*i), src[i]);
  endtask

  // Word average over eight of the sixteen alignment pairs, truncate and reverse mix, slot order varied.
  task automatic t_word();
    logic [1:0] i0;
    logic [1:0] i1;
    logic [1:0] p0;
    logic [2:0] ot;
    logic [2:0] orv;
    for (int i = 0; i < 16; i++) begin
      i0 = i[1:0];
      i1 = 2'(3 - i[1:0]) ^ {1'b0, i[3]};
      p0 = i[0] ? qba_pkg::PAIR_R32 : qba_pkg::PAIR_R10;
      ot = i[2] ? qba_pkg::OPT_TRUNC : qba_pkg::OPT_NONE;
      orv = i[3] ? qba_pkg::OPT_REV : qba_pkg::OPT_NONE;
      wr(qba_pkg::OFF_IDX0, {8'hA5, 22'h0, i0});
      wr(qba_pkg::OFF_IDX1, {8'h5A, 22'h0, i1});
      // The second pair is the other legal one; inverting both bits would name a refused pair.
      issue(i[0] ? cmd(1'b0, 3'(i), p0, p0 ^ 2'h1, orv, 3'h0, ot, i[0])
                 : cmd(1'b0, 3'(i), p0, p0 ^ 2'h1, ot, orv, 3'h0, i[0]),
            eWord(pick(p0, i[3], i0), pick(p0 ^ 2'h1, i[3], i1), i[2]),
            i[0] ? 32'h0000_000D : 32'h0000_0005);
    end
  endtask

  // Half-word average; index one holds a decoy that must be ignored.
  task automatic t_half();
    logic [1:0] i0;
    logic [2:0] pl;
    logic [2:0] ot;
    logic [2:0] orv;
    for (int i = 0; i < 16; i++) begin
      i0 = i[1:0];
      pl = (i % 3 == 0) ? qba_pkg::OPT_NONE : (i % 3 == 1) ? qba_pkg::OPT_LOW : qba_pkg::OPT_HIGH;
      ot = i[2] ? qba_pkg::OPT_TRUNC : qba_pkg::OPT_NONE;
      orv = i[3] ? qba_pkg::OPT_REV : qba_pkg::OPT_NONE;
      wr(qba_pkg::OFF_IDX0, {30'h0, i0});
      wr(qba_pkg::OFF_IDX1, {30'h0, ~i0});
      issue(i[0] ? cmd(1'b1, 3'(i), 2'h0, 2'h1, pl, orv, ot, i[1])
                 : cmd(1'b1, 3'(i), 2'h0, 2'h1, ot, pl, orv, i[1]),
            eHalf(pick(2'h0, i[3], i0), pick(2'h1, i[3], i0), i[2], i % 3 == 2),
            i[1] ? 32'h0000_000D : 32'h0000_0005);
    end
  endtask

  // Global rounding mode set; results round by the command alone, status untouched.
  task automatic t_arithmetic_status_word();
    logic [31:0] v;
    wr(qba_pkg::OFF_ARITHMETIC_STATUS_WORD, 32'h0000_0100);
    wr(qba_pkg::OFF_IDX0, 32'h0000_0002);
    issue(cmd(1'b0, 3'h7, 2'h0, 2'h1, 3'h0, 3'h0, 3'h0, 1'b0),
          eWord(pick(2'h0, 1'b0, 2'h2), pick(2'h1, 1'b0, 2'h0), 1'b0), 32'h5);
    issue(cmd(1'b1, 3'h6, 2'h1, 2'h0, 3'h0, 3'h0, 3'h0, 1'b0),
          eHalf(pick(2'h1, 1'b0, 2'h2), pick(2'h0, 1'b0, 2'h2), 1'b0, 1'b0), 32'h5);
    // Pairs in order with fixed alignments, so each word-average datapath assertion gets a trigger.
    wr(qba_pkg::OFF_IDX0, 32'h0000_0000);
    wr(qba_pkg::OFF_IDX1, 32'h0000_0000);
    issue(cmd(1'b0, 3'h5, 2'h0, 2'h1, 3'h0, 3'h0, 3'h0, 1'b0),
          eWord(pick(2'h0, 1'b0, 2'h0), pick(2'h1, 1'b0, 2'h0), 1'b0), 32'h5);
    issue(cmd(1'b0, 3'h4, 2'h0, 2'h1, qba_pkg::OPT_TRUNC, qba_pkg::OPT_REV, 3'h0, 1'b0),
          eWord(pick(2'h0, 1'b1, 2'h0), pick(2'h1, 1'b1, 2'h0), 1'b1), 32'h5);
    wr(qba_pkg::OFF_IDX0, 32'h0000_0003);
    wr(qba_pkg::OFF_IDX1, 32'h0000_0003);
    issue(cmd(1'b0, 3'h3, 2'h0, 2'h1, 3'h0, 3'h0, qba_pkg::OPT_TRUNC, 1'b0),
          eWord(pick(2'h0, 1'b0, 2'h3), pick(2'h1, 1'b0, 2'h3), 1'b1), 32'h5);
    rd(qba_pkg::OFF_ARITHMETIC_STATUS_WORD, v);
    check(v, 32'h0000_0100);
  endtask

  // Illegal commands and unmapped places leave the destination alone.
  task automatic t_refuse();
    logic [31:0] prev;
    logic [31:0] v;
    logic [31:0] bad [3];
    bad = '{cmd(1'b0, 3'h1, 2'h2, 2'h0, 3'h0, 3'h0, 3'h0, 1'b0),
            cmd(1'b1, 3'h1, 2'h0, 2'h1, 3'h5, 3'h0, 3'h0, 1'b0),
            cmd(1'b0, 3'h1, 2'h0, 2'h1, 3'h0, qba_pkg::OPT_LOW, 3'h0, 1'b0)};
    rd(qba_pkg::OFF_RESULT, prev);
    rd(8'h28, v);
    check({v[31:1], lastErr}, 32'h0000_0001);
    wr(8'h26, 32'hFFFF_FFFF);
    check({31'h0, lastErr}, 32'h0000_0001);
    wr(qba_pkg::OFF_RESULT, 32'hFFFF_FFFF);
    foreach (bad[i]) begin
      v = {24'h0, wrCount_q};
      wr(qba_pkg::OFF_CMD, bad[i]);
      repeat (6) @(posedge clock);
      check({24'h0, wrCount_q}, v);
      rd(qba_pkg::OFF_STATUS, v);
      check({30'h0, v[1:0]}, 32'h0000_0002);
      rd(qba_pkg::OFF_RESULT, v);
      check(v, prev);
    end
  endtask

  // Watchdog sized well beyond the thousand or so cycles the sequence needs.
  initial begin
    #400000;
    n_fail++;
    finish_test();
  end

  // Main sequence: six reset cycles, then each scenario in turn.
  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    t_reset();
    t_word();
    t_half();
    t_arithmetic_status_word();
    t_refuse();
    finish_test();
  end
endmodule // quad_byte_average_unit_tb_top

`default_nettype wire
